//--- sdc_afe_model.sv
`timescale 1ns/1ns
`default_nettype none
module sdc_afe_model #(
  parameter int BIT_CLKS = 12
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Control
  input wire logic modulatorOn,
  input wire logic [1:0] pattern,
  // Bitstream
  output logic modBit
);
  int cnt;
  logic [1:0] slot;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
    end else begin
      cnt <= (cnt == 4 * BIT_CLKS - 1) ? 0 : cnt + 1;
    end
  end
  assign slot = 2'(cnt / BIT_CLKS);
  // Idle line toggles so a stale bit never looks like data
  always_comb begin
    if (!modulatorOn) begin
      modBit = cnt[0];
    end else begin
      case (pattern)
        2'h0: modBit = 1'b1;
        2'h1: modBit = 1'b0;
        2'h2: modBit = (slot != 2'h3);
        default: modBit = (slot == 2'h3);
      endcase
    end
  end
endmodule : sdc_afe_model
`default_nettype wire

//--- sdc_cfg.svh
`ifndef SDC_CFG_SVH
`define SDC_CFG_SVH
// Register word offsets
`define SDC_OFS_CTRL_A 3'h0
`define SDC_OFS_CTRL_B 3'h1
`define SDC_OFS_CLOCK 3'h2
`define SDC_OFS_CHAN 3'h3
`define SDC_OFS_RES_LOW 3'h4
`define SDC_OFS_RES_MID 3'h5
`define SDC_OFS_RES_HIGH 3'h6
`define SDC_OFS_POWER 3'h7
// Writable bits and reset values
`define SDC_CTRL_A_MASK 8'hFC
`define SDC_CTRL_A_RST 8'h20
`define SDC_CTRL_B_MASK 8'hE4
`define SDC_CLOCK_MASK 8'h1F
`define SDC_CHAN_MASK 8'hFF
`define SDC_POWER_MASK 8'h07
`define SDC_ZERO_BYTE 8'h00
// Field positions
`define SDC_BIT_FRST 7
`define SDC_BIT_SLEEP 6
`define SDC_BIT_POFF 5
`define SDC_OSR_HI 4
`define SDC_OSR_LO 2
`define SDC_CHOP_HI 7
`define SDC_CHOP_DIV 6
`define SDC_CHOP_ONE 7
`define SDC_CHOP_LO 5
`define SDC_BIT_HOLD 2
`define SDC_BIT_DONE 1
`define SDC_DIV_HI 4
`define SDC_NEG_HI 7
`define SDC_NEG_LO 4
`define SDC_POS_HI 3
`define SDC_POS_LO 0
`define SDC_BIT_REGEN 0
`define SDC_BIT_GIE 1
`define SDC_BIT_CIE 2
`define SDC_BIT_IRQF 3
// Codes and counts
`define SDC_DIV_BYPASS 5'h1F
`define SDC_TEMP_SEL 4'h7
`define SDC_ADCK_LONG 5'h1E
`define SDC_ADCK_SHORT 5'h0C
`define SDC_OSR_MAX_LOG2 5'h0E
`define SDC_RES_LOG2 5'h17
`define SDC_POS_FULL 24'h7FFFFF
`define SDC_NEG_FULL 24'h800000
`endif

//--- sdc_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
`include "sdc_cfg.svh"
// Overview of operation
// - Power-off with regulator disabled shuts every analog and filter block down.
// - Power-off with regulator enabled keeps only bandgap and regulator running.
// - Sleep keeps bandgap, amplifier and filter on; modulator and sensor off.
// - Normal mode runs modulator and filter; regulator follows its enable.
// - Filter reset bit high holds the filter; its falling edge starts converting.
// - Temperature sensor on in normal and reset modes when an input selects it.
// - Done flag set at the end of every conversion while hold is off.
// - Interrupt request flag set with done; interrupt output only when enabled.
// - Without hold every new result overwrites the result registers.
// - With hold, the latest result stays; later results are discarded.
// - Converter clock is system clock, direct or divided by twice the divider field plus two.
// - Power-off stops all converter power draw except bandgap and regulator when the regulator is enabled.
// - Results are 24-bit two's complement, sign in the top bit.
// - Out-of-range results clamp to positive maximum or negative minimum.
// - Result equals input over reference ratio times two to the 23rd.
// - While hold is on, no interrupt is raised and done is unchanged.
// - Oversampling field 000..111 selects ratios 16384 halving to 128.
module sdc_ctrl import sdc_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Modulator bitstream
  input wire logic modBit,
  // Analog power and filter controls
  output logic bandgapOn,
  output logic regulatorOn,
  output logic ampOn,
  output logic modulatorOn,
  output logic tempSensorOn,
  output logic filterOn,
  output logic filterRst,
  // Converter interrupt
  output logic convIrq
);
  sdc_filt_if fl ();

  sdc_filter #(.ACC_W(17)) uFilter (
    .clock(clock),
    .rst_n(rst_n),
    .fl(fl.filt)
  );

  // Register state
  logic [7:0] ctrlA, next_ctrlA;
  logic [7:0] ctrlB, next_ctrlB;
  logic [7:0] clkSel, next_clkSel;
  logic [7:0] chanSel, next_chanSel;
  logic [7:0] powerReg, next_powerReg;
  logic done, next_done;
  logic irqFlag, next_irqFlag;
  sdc_result_t result, next_result;
  logic [31:0] next_readdata;
  logic next_waitrequest;
  logic busReq, wrEn, capture, hold;
  logic [7:0] rdByte;

  assign busReq = avs_read || avs_write;
  assign wrEn = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign hold = ctrlB[`SDC_BIT_HOLD];
  assign capture = fl.resultValid && !hold;

  always_comb begin
    unique case (avs_address)
      `SDC_OFS_CTRL_A: rdByte = ctrlA;
      `SDC_OFS_CTRL_B: rdByte = {ctrlB[7:2], done, 1'b0};
      `SDC_OFS_CLOCK: rdByte = clkSel;
      `SDC_OFS_CHAN: rdByte = chanSel;
      `SDC_OFS_RES_LOW: rdByte = result[7:0];
      `SDC_OFS_RES_MID: rdByte = result[15:8];
      `SDC_OFS_RES_HIGH: rdByte = result[23:16];
      `SDC_OFS_POWER: rdByte = {4'h0, irqFlag, powerReg[2:0]};
    endcase
    // One wait cycle, then the access completes
    next_waitrequest = !(busReq && avs_waitrequest);
    next_readdata = avs_readdata;
    if (avs_read && avs_waitrequest) begin
      next_readdata = {24'h000000, rdByte};
    end
    next_ctrlA = ctrlA;
    next_ctrlB = ctrlB;
    next_clkSel = clkSel;
    next_chanSel = chanSel;
    next_powerReg = powerReg;
    next_done = done;
    next_irqFlag = irqFlag;
    next_result = result;
    if (wrEn) begin
      unique case (avs_address)
        `SDC_OFS_CTRL_A: next_ctrlA = avs_writedata[7:0] & `SDC_CTRL_A_MASK;
        `SDC_OFS_CTRL_B: begin
          next_ctrlB = avs_writedata[7:0] & `SDC_CTRL_B_MASK;
          if (!avs_writedata[`SDC_BIT_DONE]) begin
            next_done = 1'b0;
          end
        end
        `SDC_OFS_CLOCK: next_clkSel = avs_writedata[7:0] & `SDC_CLOCK_MASK;
        `SDC_OFS_CHAN: next_chanSel = avs_writedata[7:0] & `SDC_CHAN_MASK;
        `SDC_OFS_POWER: begin
          next_powerReg = avs_writedata[7:0] & `SDC_POWER_MASK;
          if (!avs_writedata[`SDC_BIT_IRQF]) begin
            next_irqFlag = 1'b0;
          end
        end
        default: next_ctrlA = ctrlA;
      endcase
    end
    // A finishing conversion beats a clear in the same cycle
    if (capture) begin
      next_done = 1'b1;
      next_irqFlag = 1'b1;
      next_result = fl.result;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrlA <= `SDC_CTRL_A_RST;
      ctrlB <= `SDC_ZERO_BYTE;
      clkSel <= `SDC_ZERO_BYTE;
      chanSel <= `SDC_ZERO_BYTE;
      powerReg <= `SDC_ZERO_BYTE;
      done <= 1'b0;
      irqFlag <= 1'b0;
      result <= '0;
      avs_readdata <= 32'h00000000;
      avs_waitrequest <= 1'b1;
    end else begin
      ctrlA <= next_ctrlA;
      ctrlB <= next_ctrlB;
      clkSel <= next_clkSel;
      chanSel <= next_chanSel;
      powerReg <= next_powerReg;
      done <= next_done;
      irqFlag <= next_irqFlag;
      result <= next_result;
      avs_readdata <= next_readdata;
      avs_waitrequest <= next_waitrequest;
    end
  end

  // Mode decode and analog enables
  sdc_mode_t mode;
  logic regEn, tempSel, armed, next_armed, frstPrev;
  logic next_bandgapOn, next_ampOn, next_modulatorOn, next_tempSensorOn;
  logic next_filterOn, next_filterRst, next_convIrq;

  assign regEn = powerReg[`SDC_BIT_REGEN];
  assign tempSel = (chanSel[`SDC_POS_HI:`SDC_POS_LO] == `SDC_TEMP_SEL)
                || (chanSel[`SDC_NEG_HI:`SDC_NEG_LO] == `SDC_TEMP_SEL);

  always_comb begin
    if (ctrlA[`SDC_BIT_POFF]) begin
      mode = SDC_PWRDN;
    end else if (ctrlA[`SDC_BIT_SLEEP]) begin
      mode = SDC_SLEEP;
    end else if (ctrlA[`SDC_BIT_FRST]) begin
      mode = SDC_RESET;
    end else begin
      mode = SDC_NORMAL;
    end
    next_bandgapOn = 1'b1;
    next_ampOn = 1'b1;
    next_modulatorOn = 1'b0;
    next_tempSensorOn = 1'b0;
    next_filterOn = 1'b1;
    next_filterRst = 1'b0;
    unique case (mode)
      SDC_PWRDN: begin
        next_bandgapOn = regEn;
        next_ampOn = 1'b0;
        next_filterOn = 1'b0;
      end
      SDC_SLEEP: begin
        next_bandgapOn = 1'b1;
      end
      SDC_NORMAL: begin
        next_modulatorOn = 1'b1;
        next_tempSensorOn = tempSel;
      end
      SDC_RESET: begin
        next_modulatorOn = 1'b1;
        next_tempSensorOn = tempSel;
        next_filterRst = 1'b1;
      end
    endcase
    // Conversions run only after a completed reset pulse
    next_armed = armed;
    if (mode == SDC_PWRDN || mode == SDC_SLEEP) begin
      next_armed = 1'b0;
    end else if (frstPrev && !ctrlA[`SDC_BIT_FRST]) begin
      next_armed = 1'b1;
    end
    next_convIrq = irqFlag && powerReg[`SDC_BIT_GIE] && powerReg[`SDC_BIT_CIE];
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bandgapOn <= 1'b0;
      regulatorOn <= 1'b0;
      ampOn <= 1'b0;
      modulatorOn <= 1'b0;
      tempSensorOn <= 1'b0;
      filterOn <= 1'b0;
      filterRst <= 1'b0;
      convIrq <= 1'b0;
      armed <= 1'b0;
      frstPrev <= 1'b0;
    end else begin
      bandgapOn <= next_bandgapOn;
      regulatorOn <= regEn;
      ampOn <= next_ampOn;
      modulatorOn <= next_modulatorOn;
      tempSensorOn <= next_tempSensorOn;
      filterOn <= next_filterOn;
      filterRst <= next_filterRst;
      convIrq <= next_convIrq;
      armed <= next_armed;
      frstPrev <= ctrlA[`SDC_BIT_FRST];
    end
  end

  // Converter clock and sample rate
  logic [5:0] divCnt, next_divCnt, divLast;
  logic [4:0] adckCnt, next_adckCnt, adckLast;
  logic mclkTick, sampleTick, next_sampleTick, modRun;

  assign modRun = (mode == SDC_NORMAL);
  assign divLast = {clkSel[`SDC_DIV_HI:0], 1'b1};
  assign adckLast = (ctrlB[`SDC_CHOP_DIV] ? `SDC_ADCK_SHORT : `SDC_ADCK_LONG) - 5'h01;

  always_comb begin
    mclkTick = 1'b0;
    next_divCnt = divCnt + 6'h01;
    if (!modRun) begin
      next_divCnt = 6'h00;
    end else if (clkSel[`SDC_DIV_HI:0] == `SDC_DIV_BYPASS) begin
      mclkTick = 1'b1;
      next_divCnt = 6'h00;
    end else if (divCnt == divLast) begin
      mclkTick = 1'b1;
      next_divCnt = 6'h00;
    end
    next_adckCnt = adckCnt;
    next_sampleTick = 1'b0;
    if (!modRun) begin
      next_adckCnt = 5'h00;
    end else if (mclkTick) begin
      if (adckCnt == adckLast) begin
        next_adckCnt = 5'h00;
        next_sampleTick = 1'b1;
      end else begin
        next_adckCnt = adckCnt + 5'h01;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      divCnt <= 6'h00;
      adckCnt <= 5'h00;
      sampleTick <= 1'b0;
    end else begin
      divCnt <= next_divCnt;
      adckCnt <= next_adckCnt;
      sampleTick <= next_sampleTick;
    end
  end

  assign fl.sampleTick = sampleTick;
  assign fl.modBit = modBit;
  assign fl.run = modRun && armed;
  assign fl.osrSel = ctrlA[`SDC_OSR_HI:`SDC_OSR_LO];
  assign fl.chopTwo = !ctrlB[`SDC_CHOP_ONE];

  default clocking cbMain @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  sequence seqStartPulse;
    $fell(ctrlA[`SDC_BIT_FRST]) && !ctrlA[`SDC_BIT_POFF] && !ctrlA[`SDC_BIT_SLEEP];
  endsequence
  sequence seqHeldResult;
    fl.resultValid && hold;
  endsequence

  AST_PD_DARK: assert property (
    ctrlA[`SDC_BIT_POFF] && !regEn |=> !bandgapOn && !regulatorOn && !ampOn
      && !modulatorOn && !tempSensorOn && !filterOn)
    else $error("power-down without regulator left a block on");
  AST_PD_REG: assert property (
    ctrlA[`SDC_BIT_POFF] && regEn |=> bandgapOn && regulatorOn && !ampOn && !filterOn)
    else $error("power-down with regulator wrong enables");
  AST_SLEEP: assert property (
    !ctrlA[`SDC_BIT_POFF] && ctrlA[`SDC_BIT_SLEEP] |=> bandgapOn && ampOn && filterOn
      && !modulatorOn && !tempSensorOn && !filterRst)
    else $error("sleep mode wrong enables");
  AST_NORMAL: assert property (
    mode == SDC_NORMAL |=> modulatorOn && filterOn && !filterRst && regulatorOn == $past(regEn))
    else $error("normal mode wrong enables");
  AST_START: assert property (
    seqStartPulse |=> armed ##1 fl.run)
    else $error("reset pulse did not start conversion");
  AST_TEMP: assert property (
    (mode == SDC_NORMAL || mode == SDC_RESET) |=> tempSensorOn == $past(tempSel))
    else $error("temperature sensor not following channel selection");
  AST_DONE: assert property (
    fl.resultValid && !hold |=> done && irqFlag)
    else $error("done or request flag not set at conversion end");
  AST_IRQ: assert property (
    irqFlag && powerReg[`SDC_BIT_GIE] && powerReg[`SDC_BIT_CIE] |=> convIrq)
    else $error("interrupt not issued while enabled");
  AST_UPDATE: assert property (
    fl.resultValid && !hold |=> result == $past(fl.result))
    else $error("result not updated");
  AST_HOLD: assert property (
    seqHeldResult |=> $stable(result) && !$rose(done) && !$rose(irqFlag))
    else $error("held result or flags changed");
endmodule : sdc_ctrl
`default_nettype wire

//--- sdc_filt_if.sv
`timescale 1ns/1ns
`default_nettype none
interface sdc_filt_if;
  logic sampleTick;
  logic modBit;
  logic run;
  logic [2:0] osrSel;
  logic chopTwo;
  logic resultValid;
  logic [23:0] result;
  modport ctrl (output sampleTick, modBit, run, osrSel, chopTwo, input resultValid, result);
  modport filt (input sampleTick, modBit, run, osrSel, chopTwo, output resultValid, result);
endinterface : sdc_filt_if
`default_nettype wire

//--- sdc_filter.sv
`timescale 1ns/1ns
`default_nettype none
`include "sdc_cfg.svh"
module sdc_filter import sdc_pkg::*; #(
  parameter int ACC_W = 17
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Control side
  sdc_filt_if.filt fl
);
  localparam int WIDE_W = ACC_W + 24;
  localparam logic signed [WIDE_W-1:0] POS_LIM = {{ACC_W{1'b0}}, `SDC_POS_FULL};
  localparam logic signed [WIDE_W-1:0] NEG_LIM = {{ACC_W{1'b1}}, `SDC_NEG_FULL};

  generate
    if (ACC_W < 17 || ACC_W > 32) begin : gBadAcc
      $error("sdc_filter: accumulator must be 17 to 32 bits");
    end
  endgenerate

  logic signed [ACC_W-1:0] acc, next_acc, sum, step;
  logic [ACC_W-1:0] cnt, next_cnt, lastCnt;
  logic valid, next_valid;
  sdc_result_t res, next_res;
  logic [4:0] log2N, shift;
  logic signed [WIDE_W-1:0] wide;

  always_comb begin
    // Samples per conversion: ratio, doubled when chopping by two
    log2N = `SDC_OSR_MAX_LOG2 - {2'h0, fl.osrSel} + {4'h0, fl.chopTwo};
    lastCnt = (ACC_W'(1) << log2N) - ACC_W'(1);
    step = fl.modBit ? ACC_W'(1) : {ACC_W{1'b1}};
    sum = acc + step;
    // Full-scale density maps to two to the 23rd
    shift = `SDC_RES_LOG2 - log2N;
    wide = WIDE_W'(sum) <<< shift;
    next_acc = acc;
    next_cnt = cnt;
    next_res = res;
    next_valid = 1'b0;
    if (!fl.run) begin
      next_acc = '0;
      next_cnt = '0;
    end else if (fl.sampleTick) begin
      if (cnt == lastCnt) begin
        next_valid = 1'b1;
        next_acc = '0;
        next_cnt = '0;
        if (wide > POS_LIM) begin
          next_res = `SDC_POS_FULL;
        end else if (wide < NEG_LIM) begin
          next_res = `SDC_NEG_FULL;
        end else begin
          next_res = wide[23:0];
        end
      end else begin
        next_acc = sum;
        next_cnt = cnt + ACC_W'(1);
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      acc <= '0;
      cnt <= '0;
      valid <= 1'b0;
      res <= '0;
    end else begin
      acc <= next_acc;
      cnt <= next_cnt;
      valid <= next_valid;
      res <= next_res;
    end
  end

  assign fl.resultValid = valid;
  assign fl.result = res;
endmodule : sdc_filter
`default_nettype wire

//--- sdc_pkg.sv
package sdc_pkg;
  typedef enum logic [1:0] {
    SDC_PWRDN,
    SDC_SLEEP,
    SDC_NORMAL,
    SDC_RESET
  } sdc_mode_t;
  typedef logic [23:0] sdc_result_t;
endpackage : sdc_pkg

//--- tb_sdc_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module tb_sdc_ctrl import sdc_pkg::*;;
  localparam logic [7:0] M_PWR [8] = '{8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h01, 8'h01, 8'h00};
  localparam logic [7:0] M_CTL [8] = '{8'h3C, 8'hFC, 8'hDC, 8'h5C, 8'h1C, 8'h1C, 8'h9C, 8'h9C};
  localparam logic [7:0] M_CHAN [8] = '{8'h77, 8'h77, 8'h77, 8'h70, 8'h07, 8'h00, 8'h70, 8'h00};
  localparam logic [6:0] M_EXP [8] = '{7'h00, 7'h60, 7'h52, 7'h72, 7'h5E, 7'h7A, 7'h7F, 7'h5B};
  localparam logic [6:0] M_MSK [8] = '{7'h7F, 7'h7F, 7'h7E, 7'h7E, 7'h7F, 7'h7F, 7'h7F, 7'h7F};
  localparam logic [2:0] ACC_ADR [4] = '{3'h0, 3'h1, 3'h2, 3'h7};
  localparam logic [7:0] ACC_EXP [4] = '{8'hFC, 8'hE4, 8'h1F, 8'h07};
  localparam logic [23:0] RES_EXP [4] = '{24'h7FFFFF, 24'h800000, 24'h400000, 24'hC00000};
  localparam logic [7:0] P_A [5] = '{8'h1C, 8'h18, 8'h1C, 8'h1C, 8'h1C};
  localparam logic [7:0] P_B [5] = '{8'hC0, 8'hC0, 8'h40, 8'hC0, 8'h80};
  localparam logic [7:0] P_CLK [5] = '{8'h1F, 8'h1F, 8'h1F, 8'h00, 8'h1F};
  localparam int P_LEN [5] = '{1536, 3072, 3072, 3072, 3840};
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] avsAddress = 3'h0;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWdata = 32'h00000000;
  logic [3:0] avsBe = 4'hF;
  logic [31:0] avsRdata;
  logic avsWait;
  logic [1:0] pat = 2'h0;
  logic modBit, bandgapOn, regulatorOn, ampOn, modulatorOn, tempSensorOn, filterOn, filterRst;
  logic convIrq;
  wire [6:0] pw = {bandgapOn, regulatorOn, ampOn, modulatorOn, tempSensorOn, filterOn, filterRst};
  int mismatches = 0;
  int n_compared = 0;
  int cyc = 0;
  int t0, t1, n;
  logic [7:0] q, q2;
  logic [23:0] res;

  always #4 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;

  sdc_ctrl DUT (.clock(clock), .rst_n(rst_n), .avs_address(avsAddress), .avs_read(avsRead),
    .avs_write(avsWrite), .avs_writedata(avsWdata), .avs_byteenable(avsBe),
    .avs_readdata(avsRdata), .avs_waitrequest(avsWait), .modBit(modBit),
    .bandgapOn(bandgapOn), .regulatorOn(regulatorOn), .ampOn(ampOn),
    .modulatorOn(modulatorOn), .tempSensorOn(tempSensorOn), .filterOn(filterOn),
    .filterRst(filterRst), .convIrq(convIrq));
  sdc_afe_model #(.BIT_CLKS(12)) afe (.clock(clock), .rst_n(rst_n),
    .modulatorOn(modulatorOn), .pattern(pat), .modBit(modBit));

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  task automatic bus(input logic doWrite, input logic [2:0] a, input logic [7:0] d,
      input logic [3:0] be, output logic [7:0] rq);
    int k;
    k = 0;
    @(posedge clock);
    avsAddress <= a;
    avsWrite <= doWrite;
    avsRead <= ~doWrite;
    avsWdata <= {24'h000000, d};
    avsBe <= be;
    // Sampled at the rising edge, before the slave updates its outputs
    do begin
      @(posedge clock);
      k++;
    end while (avsWait !== 1'b0 && k < 50);
    `CHK("waitrequest", 1'b0, avsWait)
    rq = avsRdata[7:0];
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
  endtask : bus

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    logic [7:0] dummy;
    bus(1'b1, a, d, 4'hF, dummy);
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [7:0] o);
    bus(1'b0, a, 8'h00, 4'hF, o);
  endtask : rd

  task automatic waitDone(output int t);
    logic [7:0] s;
    int k;
    s = 8'h00;
    k = 0;
    while (s[1] !== 1'b1 && k < 2500) begin
      rd(3'h1, s);
      k++;
    end
    `CHK("done", 1'b1, s[1])
    t = cyc;
  endtask : waitDone

  task automatic readRes(output logic [23:0] r);
    rd(3'h4, r[7:0]);
    rd(3'h5, r[15:8]);
    rd(3'h6, r[23:16]);
  endtask : readRes

  task automatic settle();
    repeat (2) @(posedge clock);
    #1;
  endtask : settle

  initial begin
    repeat (90000) @(posedge clock);
    mismatches++;
    $display("[ERR] watchdog expected finish seen hang");
    print_verdict();
  end

  initial begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    #1 `CHK("power outputs", 7'h00, pw)
    for (int i = 0; i < 4; i++) begin
      rd(3'(i), q);
      `CHK("reset value", (i == 0) ? 8'h20 : 8'h00, q)
    end
    rd(3'h7, q);
    `CHK("reset value", 8'h00, q)
    for (int i = 0; i < 4; i++) begin
      wr(ACC_ADR[i], 8'hFF);
      rd(ACC_ADR[i], q);
      `CHK("access", ACC_EXP[i], q)
    end
    rd(3'h4, q2);
    wr(3'h4, 8'hFF);
    rd(3'h4, q);
    `CHK("result read only", q2, q)
    bus(1'b1, 3'h0, 8'h00, 4'h0, q);
    rd(3'h0, q);
    `CHK("byteenable", 8'hFC, q)
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      wr(3'h3, M_CHAN[i]);
      wr(3'h7, M_PWR[i]);
      wr(3'h0, M_CTL[i]);
      settle();
      `CHK("mode outputs", M_EXP[i] & M_MSK[i], pw & M_MSK[i])
    end
    $display("test modes done");
    wr(3'h2, 8'h1F);
    wr(3'h3, 8'h00);
    wr(3'h7, 8'h01);
    wr(3'h1, 8'hC0);
    wr(3'h0, 8'h9C);
    wr(3'h0, 8'h1C);
    for (int p = 0; p < 4; p++) begin
      pat <= 2'(p);
      wr(3'h1, 8'hC0);
      waitDone(t0);
      wr(3'h1, 8'hC0);
      waitDone(t0);
      readRes(res);
      `CHK("result", RES_EXP[p], res)
    end
    $display("test results done");
    for (int k = 0; k < 5; k++) begin
      wr(3'h2, P_CLK[k]);
      wr(3'h1, P_B[k]);
      wr(3'h0, P_A[k] | 8'h80);
      wr(3'h0, P_A[k]);
      waitDone(t0);
      wr(3'h1, P_B[k]);
      waitDone(t1);
      `CHK("period", 1'b1, (t1 - t0 >= P_LEN[k] - 8) && (t1 - t0 <= P_LEN[k] + 8))
    end
    $display("test periods done");
    wr(3'h2, 8'h1F);
    pat <= 2'h0;
    wr(3'h1, 8'hC0);
    waitDone(t0);
    wr(3'h1, 8'hC0);
    waitDone(t0);
    wr(3'h1, 8'hC4);
    wr(3'h7, 8'h01);
    pat <= 2'h1;
    repeat (3400) @(posedge clock);
    rd(3'h1, q);
    `CHK("done under hold", 8'hC4, q)
    rd(3'h7, q);
    `CHK("flag under hold", 8'h01, q)
    readRes(res);
    `CHK("held result", 24'h7FFFFF, res)
    wr(3'h1, 8'hC0);
    waitDone(t0);
    readRes(res);
    `CHK("result after hold", 24'h800000, res)
    $display("test hold done");
    wr(3'h7, 8'h07);
    n = 0;
    while (convIrq !== 1'b1 && n < 4000) begin
      @(posedge clock);
      n++;
    end
    `CHK("irq", 1'b1, convIrq)
    rd(3'h7, q);
    `CHK("irq flag", 8'h0F, q)
    wr(3'h7, 8'h0B);
    settle();
    `CHK("irq masked", 1'b0, convIrq)
    wr(3'h7, 8'h0D);
    settle();
    `CHK("irq global off", 1'b0, convIrq)
    wr(3'h7, 8'h0F);
    settle();
    `CHK("irq again", 1'b1, convIrq)
    wr(3'h7, 8'h07);
    settle();
    `CHK("irq cleared", 1'b0, convIrq)
    $display("test irq done");
    wr(3'h0, 8'h3C);
    wr(3'h7, 8'h00);
    settle();
    `CHK("power off", 7'h00, pw)
    $display("test power off done");
    print_verdict();
  end
endmodule : tb_sdc_ctrl
`default_nettype wire
